//--- hw/ipl2_pkg.sv
// Package for the second interrupt pending latch: register map, fields, reset values.
// Assumes a classic Wishbone slave with 32-bit data, byte addresses, one word per register.
package ipl2_pkg;
  // ==========================================================================
  // Register offsets
  localparam logic [7:0] IPL2_PEND_OFS = 8'h00;
  localparam logic [7:0] IPL2_MASK_OFS = 8'h04;
  localparam logic [7:0] IPL2_STAT_OFS = 8'h08;
  // ==========================================================================
  // Pending field positions
  localparam int IPL2_BIT_P31 = 5;
  localparam int IPL2_BIT_P30 = 4;
  localparam int IPL2_BIT_WATCH = 3;
  localparam int IPL2_BIT_SERIAL = 2;
  localparam int IPL2_BIT_TIMERB = 1;
  localparam int IPL2_BIT_TIMER1A = 0;
  localparam int IPL2_NSRC = 6;
  // ==========================================================================
  // Reset values
  localparam logic [5:0] IPL2_PEND_RST = 6'h00;
  localparam logic [5:0] IPL2_MASK_RST = 6'h00;
  localparam logic [5:0] IPL2_STAT_RST = 6'h00;
  // Unmapped reads return this value.
  localparam logic [31:0] IPL2_UNMAPPED = 32'h0000_0000;

  typedef enum logic [1:0] {
    IPL2_IDLE = 2'b00,
    IPL2_ACK = 2'b01
  } ipl2_state_t;

  typedef struct packed {
    logic pinP31;
    logic pinP30;
    logic watchTimer;
    logic serialIoUnit;
    logic timerB;
    logic timer1A;
  } ipl2_src_t;
endpackage : ipl2_pkg

//--- hw/ipl2_sync.sv
// Two-flop synchroniser plus rising-edge pulse for one asynchronous pin.
// Assumes the pin is held for at least two clock periods.
`timescale 1ns/1ps
module ipl2_sync
  import ipl2_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic pinIn,
  output logic risePulse
);
  logic meta_q, meta_d;
  logic sync_q, sync_d;
  logic prev_q, prev_d;

  always_comb begin
    meta_d = pinIn;
    sync_d = meta_q;
    prev_d = sync_q;
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      prev_q <= 1'b0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
      prev_q <= prev_d;
    end
  end

  assign risePulse = sync_q & ~prev_q;
endmodule : ipl2_sync

//--- hw/ipl2_flag.sv
// One pending flag: set by an event, cleared by a software write of 0.
// Assumes the event is a one-cycle pulse in the clock domain.
`timescale 1ns/1ps
module ipl2_flag
  import ipl2_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic setPulse,
  input wire logic clrPulse,
  output logic flag
);
  logic flag_q, flag_d;

  always_comb begin
    flag_d = flag_q;
    if (clrPulse) begin
      flag_d = 1'b0;
    end
    // Set wins over clear so no request is dropped.
    if (setPulse) begin
      flag_d = 1'b1;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      flag_q <= 1'b0;
    end else begin
      flag_q <= flag_d;
    end
  end

  assign flag = flag_q;

  // ==========================================================================
  // Checks
  set_wins_a: assert property (@(posedge clock) disable iff (rst)
    setPulse |=> flag) else $error("Set did not win over clear.");
  clr_works_a: assert property (@(posedge clock) disable iff (rst)
    (clrPulse && !setPulse) |=> !flag) else $error("Clear did not clear flag.");
  hold_flag_a: assert property (@(posedge clock) disable iff (rst)
    (!clrPulse && !setPulse) |=> flag == $past(flag)) else $error("Flag changed idly.");
endmodule : ipl2_flag

//--- hw/ipl2_top.sv
// Second interrupt pending latch with a classic Wishbone register port.
// Assumes timer and serial events are one-cycle pulses on clock; port 3 pins are asynchronous.
//
// The Wishbone register port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
// Functional notes
// - Bit 5 pends the port 3 pin 1 external interrupt.
// - Bit 4 pends the port 3 pin 0 external interrupt.
// - Bit 3 pends the watch timer interrupt.
// - Bit 2 pends the serial unit interrupt.
// - Bit 1 pends the timer B interrupt.
// - Pending flags read as 1; bits 7 and 6 unused; reset clears all.
// - Read 0 means nothing pending; writing 0 clears that flag.
module ipl2_top
  import ipl2_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic port3_pin1,
  input wire logic port3_pin0,
  input wire logic watchTimerEvent,
  input wire logic serialIoUnitEvent,
  input wire logic timerBEvent,
  input wire logic timer1AEvent,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic irq,
  output logic [5:0] pendingFlags
);
  // ==========================================================================
  // Event sources
  ipl2_src_t evt;
  logic [5:0] evtVec;
  logic [5:0] clrVec;
  logic [5:0] pend;

  ipl2_sync u_sync31 (
    .clock(clock),
    .rst(rst),
    .pinIn(port3_pin1),
    .risePulse(evt.pinP31)
  );
  ipl2_sync u_sync30 (
    .clock(clock),
    .rst(rst),
    .pinIn(port3_pin0),
    .risePulse(evt.pinP30)
  );
  assign evt.watchTimer = watchTimerEvent;
  assign evt.serialIoUnit = serialIoUnitEvent;
  assign evt.timerB = timerBEvent;
  assign evt.timer1A = timer1AEvent;
  // Struct order puts pin 1 at bit 5 down to timer 1/A at bit 0.
  assign evtVec = evt;

  genvar gi;
  generate
    for (gi = 0; gi < IPL2_NSRC; gi++) begin : g_flag
      ipl2_flag u_flag (
        .clock(clock),
        .rst(rst),
        .setPulse(evtVec[gi]),
        .clrPulse(clrVec[gi]),
        .flag(pend[gi])
      );
    end
  endgenerate

  // ==========================================================================
  // Wishbone slave: each request is answered in the cycle after it is taken.
  ipl2_state_t state_q, state_d;
  logic [5:0] mask_q, mask_d;
  logic [5:0] stat_q, stat_d;
  logic [31:0] rdat_q, rdat_d;
  logic [5:0] wrVal;
  logic req;
  logic wrPend;
  logic wrMask;
  logic rdPend;
  logic rdMask;
  logic rdStat;
  logic rdOther;

  function automatic logic hit(input logic [7:0] adr, input logic [7:0] ofs);
    hit = (adr[7:2] == ofs[7:2]);
  endfunction : hit

  // Only lane 0 carries flags; a write without sel[0] changes nothing.
  assign wrVal = wb_dat_i[5:0];
  assign req = wb_cyc_i & wb_stb_i & (state_q == IPL2_IDLE);
  assign wrPend = req & wb_we_i & wb_sel_i[0] & hit(wb_adr_i, IPL2_PEND_OFS);
  assign wrMask = req & wb_we_i & wb_sel_i[0] & hit(wb_adr_i, IPL2_MASK_OFS);
  assign rdPend = req & ~wb_we_i & hit(wb_adr_i, IPL2_PEND_OFS);
  assign rdMask = req & ~wb_we_i & hit(wb_adr_i, IPL2_MASK_OFS);
  assign rdStat = req & ~wb_we_i & hit(wb_adr_i, IPL2_STAT_OFS);
  assign rdOther = req & ~wb_we_i & ~rdPend & ~rdMask & ~rdStat;
  // Only zeros clear and ones are ignored, so software can clear one flag alone.
  assign clrVec = wrPend ? ~wrVal : 6'h00;

  // ==========================================================================
  // Handshake state
  always_comb begin
    state_d = state_q;
    case (state_q)
      IPL2_IDLE: begin
        if (req) begin
          state_d = IPL2_ACK;
        end
      end
      IPL2_ACK: begin
        // A request still held in the ack cycle is not taken a second time.
        state_d = IPL2_IDLE;
      end
      default: begin
        state_d = IPL2_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_q <= IPL2_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // ==========================================================================
  // Interrupt mask
  always_comb begin
    mask_d = mask_q;
    if (wrMask) begin
      mask_d = wrVal;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      mask_q <= IPL2_MASK_RST;
    end else begin
      mask_q <= mask_d;
    end
  end

  // ==========================================================================
  // Event status: a sticky copy of every event, emptied by a read.
  always_comb begin
    stat_d = stat_q | evtVec;
    // An event in the cycle of the read survives, so no interrupt is lost.
    if (rdStat) begin
      stat_d = evtVec;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      stat_q <= IPL2_STAT_RST;
    end else begin
      stat_q <= stat_d;
    end
  end

  // ==========================================================================
  // Read data: loaded at the taking edge and held until the next read.
  always_comb begin
    rdat_d = rdat_q;
    if (rdPend) begin
      rdat_d = {26'h0, pend};
    end else if (rdMask) begin
      rdat_d = {26'h0, mask_q};
    end else if (rdStat) begin
      rdat_d = {26'h0, stat_q};
    end else if (rdOther) begin
      rdat_d = IPL2_UNMAPPED;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rdat_q <= 32'h0000_0000;
    end else begin
      rdat_q <= rdat_d;
    end
  end

  // ==========================================================================
  // Outputs
  assign wb_ack_o = (state_q == IPL2_ACK);
  assign wb_dat_o = rdat_q;
  // The line follows status, not the flags, so clearing a flag leaves it alone.
  assign irq = |(stat_q & mask_q);
  assign pendingFlags = pend;

  // ==========================================================================
  // Checks: event sources
  timer_sets_a: assert property (@(posedge clock) disable iff (rst)
    timerBEvent |=> pendingFlags[IPL2_BIT_TIMERB])
    else $error("Timer B not pended.");

  watch_sets_a: assert property (@(posedge clock) disable iff (rst)
    watchTimerEvent |=> pendingFlags[IPL2_BIT_WATCH])
    else $error("Watch not pended.");

  serial_sets_a: assert property (@(posedge clock) disable iff (rst)
    serialIoUnitEvent |=> pendingFlags[IPL2_BIT_SERIAL])
    else $error("Serial not pended.");

  t1a_sets_a: assert property (@(posedge clock) disable iff (rst)
    timer1AEvent |=> pendingFlags[IPL2_BIT_TIMER1A])
    else $error("Timer 1/A not pended.");

  pin1_sets_a: assert property (@(posedge clock) disable iff (rst)
    $rose(port3_pin1) ##1 port3_pin1 [*2] |=> pendingFlags[IPL2_BIT_P31])
    else $error("Pin 1 not pended.");

  pin0_sets_a: assert property (@(posedge clock) disable iff (rst)
    $rose(port3_pin0) ##1 port3_pin0 [*2] |=> pendingFlags[IPL2_BIT_P30])
    else $error("Pin 0 not pended.");

  // ==========================================================================
  // Checks: pending register
  pend_read_a: assert property (@(posedge clock) disable iff (rst)
    rdPend |=> wb_ack_o && wb_dat_o == {26'h0, $past(pendingFlags)})
    else $error("Pending read wrong.");

  upper_zero_a: assert property (@(posedge clock) disable iff (rst)
    wb_ack_o |-> wb_dat_o[31:6] == 26'h0)
    else $error("Unused read bits not zero.");

  write_clear_a: assert property (@(posedge clock) disable iff (rst)
    (wrPend && !wrVal[IPL2_BIT_TIMERB] && !timerBEvent) |=> !pendingFlags[IPL2_BIT_TIMERB])
    else $error("Zero write did not clear.");

  write_clear_all_a: assert property (@(posedge clock) disable iff (rst)
    (wrPend && evtVec == 6'h00) |=> pendingFlags == ($past(pendingFlags) & $past(wrVal)))
    else $error("Pending write result wrong.");

  keep_on_one_a: assert property (@(posedge clock) disable iff (rst)
    (wrPend && wrVal == 6'h3F) |=> pendingFlags == ($past(pendingFlags) | $past(evtVec)))
    else $error("Write of ones changed flags.");

  flags_hold_a: assert property (@(posedge clock) disable iff (rst)
    !wrPend |=> (pendingFlags & $past(pendingFlags)) == $past(pendingFlags))
    else $error("Flag cleared without a write.");

  set_beats_clear_a: assert property (@(posedge clock) disable iff (rst)
    (wrPend && evtVec[IPL2_BIT_TIMERB]) |=> pendingFlags[IPL2_BIT_TIMERB])
    else $error("Clear beat a coinciding event.");

  // ==========================================================================
  // Checks: bus handshake
  ack_after_req_a: assert property (@(posedge clock) disable iff (rst)
    req |=> wb_ack_o)
    else $error("Request not acknowledged.");

  ack_pulse_a: assert property (@(posedge clock) disable iff (rst)
    wb_ack_o |=> !wb_ack_o)
    else $error("Acknowledge longer than one cycle.");

  ack_only_req_a: assert property (@(posedge clock) disable iff (rst)
    !req |=> !wb_ack_o)
    else $error("Acknowledge without request.");

  dat_hold_a: assert property (@(posedge clock) disable iff (rst)
    !(req && !wb_we_i) |=> $stable(wb_dat_o))
    else $error("Read data moved without a read.");

  unmapped_read_a: assert property (@(posedge clock) disable iff (rst)
    rdOther |=> wb_dat_o == IPL2_UNMAPPED)
    else $error("Unmapped read not zero.");

  sel_ignore_a: assert property (@(posedge clock) disable iff (rst)
    (req && wb_we_i && !wb_sel_i[0]) |=> $stable(mask_q))
    else $error("Write without lane 0 took effect.");

  // ==========================================================================
  // Checks: mask, status and interrupt
  mask_write_a: assert property (@(posedge clock) disable iff (rst)
    wrMask |=> mask_q == $past(wrVal))
    else $error("Mask write lost.");

  mask_read_a: assert property (@(posedge clock) disable iff (rst)
    rdMask |=> wb_dat_o == {26'h0, $past(mask_q)})
    else $error("Mask read wrong.");

  mask_zero_a: assert property (@(posedge clock) disable iff (rst)
    (wrMask && wrVal == 6'h00) |=> !irq)
    else $error("Interrupt with mask cleared.");

  stat_read_a: assert property (@(posedge clock) disable iff (rst)
    rdStat |=> wb_dat_o == {26'h0, $past(stat_q)})
    else $error("Status read wrong.");

  stat_clear_a: assert property (@(posedge clock) disable iff (rst)
    (rdStat && evtVec == 6'h00) |=> stat_q == 6'h00)
    else $error("Status read did not clear.");

  stat_sticky_a: assert property (@(posedge clock) disable iff (rst)
    !rdStat |=> (stat_q & $past(stat_q)) == $past(stat_q))
    else $error("Status bit lost without a read.");

  irq_event_a: assert property (@(posedge clock) disable iff (rst)
    |(evtVec & mask_d) |=> irq)
    else $error("Unmasked event raised no interrupt.");
endmodule : ipl2_top

//--- testbench/ipl2_src_model.sv
// Model of the event sources: timer and serial pulses, port 3 pins as levels.
// Assumes the bench raises fire bits for one cycle just after a clock edge.
`timescale 1ns/1ps
module ipl2_src_model
  import ipl2_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire ipl2_src_t fire,
  output ipl2_src_t src
);
  logic [2:0] p1Cnt_q;
  logic [2:0] p0Cnt_q;
  // ==========================================================================
  // Pins stay high four cycles, since the synchroniser needs two.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      p1Cnt_q <= 3'h0;
      p0Cnt_q <= 3'h0;
    end else begin
      p1Cnt_q <= fire.pinP31 ? 3'h4 : ((p1Cnt_q != 3'h0) ? p1Cnt_q - 3'h1 : 3'h0);
      p0Cnt_q <= fire.pinP30 ? 3'h4 : ((p0Cnt_q != 3'h0) ? p0Cnt_q - 3'h1 : 3'h0);
    end
  end
  always_comb begin
    src = fire;
    src.pinP31 = (p1Cnt_q != 3'h0);
    src.pinP30 = (p0Cnt_q != 3'h0);
  end
endmodule : ipl2_src_model

//--- testbench/tb_top.sv
// Self-checking bench for the pending latch over classic Wishbone.
// Assumes the event source model drives all six event inputs.
`timescale 1ns/1ps
module tb_top
  import ipl2_pkg::*;
;
  logic clock, rst, wbCyc, wbStb, wbWe, ack, irq;
  logic [7:0] wbAdr;
  logic [3:0] wbSel;
  logic [31:0] wbDatW, datO;
  logic [5:0] pend, pendExp, w;
  ipl2_src_t fire, src;
  logic [31:0] expQ[$];
  int seed = 32'haac3;
  int bad_count = 0;
  int samples_checked = 0;
  ipl2_src_model src_u (.clock(clock), .rst(rst), .fire(fire), .src(src));
  ipl2_top dut_u (.clock(clock), .rst(rst), .port3_pin1(src.pinP31),
    .port3_pin0(src.pinP30), .watchTimerEvent(src.watchTimer),
    .serialIoUnitEvent(src.serialIoUnit), .timerBEvent(src.timerB),
    .timer1AEvent(src.timer1A), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe),
    .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDatW), .wb_dat_o(datO),
    .wb_ack_o(ack), .irq(irq), .pendingFlags(pend));
  // ==========================================================================
  // Shared tasks
  task check_read(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("Error %0t: read %h expected %h", $time, got, exp);
    end
  endtask : check_read
  task check_pend(input logic [5:0] exp);
    samples_checked++;
    if (pend !== exp) begin
      bad_count++;
      $display("Error %0t: flags %h expected %h", $time, pend, exp);
    end
  endtask : check_pend
  task check_irq(input logic exp);
    samples_checked++;
    if (irq !== exp) begin
      bad_count++;
      $display("Error %0t: irq %b expected %b", $time, irq, exp);
    end
  endtask : check_irq
  task bus(input logic we, input logic [7:0] adr, input logic [31:0] d);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= we;
    wbAdr <= adr;
    wbDatW <= d;
    @(posedge clock);
    while (ack !== 1'b1) @(posedge clock);
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    @(posedge clock);
  endtask : bus
  task rd(input logic [7:0] adr, input logic [31:0] exp);
    expQ.push_back(exp);
    bus(1'b0, adr, 32'h0);
  endtask : rd
  task fire_src(input logic [5:0] f);
    fire <= ipl2_src_t'(f);
    @(posedge clock);
    fire <= '0;
  endtask : fire_src
  task results;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : results
  // ==========================================================================
  // Read data is sampled at the ack edge, before the registers move on.
  always @(posedge clock) begin
    if (ack === 1'b1 && wbWe === 1'b0 && expQ.size() > 0) check_read(datO, expQ.pop_front());
  end
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  initial begin
    #100000;
    bad_count++;
    results();
  end
  initial begin
    {wbCyc, wbStb, wbWe, wbAdr, wbDatW} = '0;
    wbSel = 4'hF;
    fire = '0;
    rst = 1'b1;
    pendExp = 6'h00;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    rd(IPL2_PEND_OFS, 32'h0);
    rd(IPL2_MASK_OFS, 32'h0);
    rd(IPL2_STAT_OFS, 32'h0);
    rd(8'h0C, IPL2_UNMAPPED);
    for (int i = 0; i < IPL2_NSRC; i++) begin
      fire_src(6'h01 << i);
      repeat (6) @(posedge clock);
      pendExp = pendExp | (6'h01 << i);
      rd(IPL2_PEND_OFS, {26'h0, pendExp});
      check_pend(pendExp);
    end
    for (int k = 0; k < 4; k++) begin
      w = 6'($random(seed));
      bus(1'b1, IPL2_PEND_OFS, {26'($random(seed)), w});
      pendExp = pendExp & w;
      rd(IPL2_PEND_OFS, {26'h0, pendExp});
      fire_src(6'h3F);
      repeat (6) @(posedge clock);
      pendExp = 6'h3F;
    end
    // The clear and the timer B event land on the same edge.
    fork
      fire_src(6'h02);
      bus(1'b1, IPL2_PEND_OFS, 32'h0);
    join
    check_pend(6'h02);
    bus(1'b1, IPL2_MASK_OFS, 32'h3F);
    rd(IPL2_MASK_OFS, 32'h3F);
    rd(IPL2_STAT_OFS, 32'h3F);
    check_irq(1'b0);
    fire_src(6'h02);
    repeat (2) @(posedge clock);
    check_irq(1'b1);
    bus(1'b1, IPL2_MASK_OFS, 32'h0);
    check_irq(1'b0);
    rd(IPL2_STAT_OFS, 32'h2);
    rd(IPL2_STAT_OFS, 32'h0);
    // A write without byte lane 0 must change neither flags nor mask.
    wbSel <= 4'hE;
    bus(1'b1, IPL2_PEND_OFS, 32'h0);
    bus(1'b1, IPL2_MASK_OFS, 32'h3F);
    wbSel <= 4'hF;
    check_pend(6'h02);
    rd(IPL2_MASK_OFS, 32'h0);
    // A reset in mid-run empties every flag, whatever was pending.
    fire_src(6'h3F);
    repeat (6) @(posedge clock);
    check_pend(6'h3F);
    rst <= 1'b1;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    check_pend(6'h00);
    @(posedge clock);
    rd(IPL2_PEND_OFS, 32'h0);
    rd(IPL2_STAT_OFS, 32'h0);
    check_irq(1'b0);
    repeat (2) @(posedge clock);
    results();
  end
endmodule : tb_top
